// [design/port_d_direction_and_latch.sv]
// port d direction register, output latches and alternate-function pin muxing
`timescale 1ns/1ps
`include "port_d_defines.svh"
module port_d_direction_and_latch
  import port_d_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu register access
  input wire reg_req_s req_i,
  output logic [7:0] rdata_o,
  // alternate function controls
  input wire logic cmp_b_output_enable_i,
  input wire logic refb_out_i,
  input wire logic cmpb_out_i,
  input wire logic serial_pin_select_i,
  input wire logic serial_enable_i,
  input wire logic serial_data_out_i,
  input wire logic serial_data_oe_i,
  input wire logic serial_clock_out_i,
  input wire logic serial_clock_oe_i,
  input wire logic [7:4] analog_select_i,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [1:0] serial_pin_level_o
);

  // refuse any width the fixed eight-pin muxing cannot serve
  if (WIDTH != 8)
  begin : g_width_check
    $error("port d is eight bits wide");
  end

  // ****************************************
  // state
  // ****************************************
  logic [7:0] port_d_direction;
  logic [7:0] port_d_latch;
  logic [7:0] next_port_d_direction;
  logic [7:0] next_port_d_latch;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_read;
  pad_drive_s pad;

  // address decode used by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // two-stage pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // pin levels as seen by a read, analog pins forced low
  always_comb
  begin
    pin_read = pin_sync;
    pin_read[7:4] = pin_sync[7:4] & ~analog_select_i;
  end

  // ****************************************
  // register next values
  // ****************************************
  always_comb
  begin
    next_port_d_direction = port_d_direction;
    next_port_d_latch = port_d_latch;
    if (req_i.wr && hit(req_i.addr, `PORT_D_DIRECTION_ADDR))
    begin
      if (req_i.bit_op)
      begin
        next_port_d_direction[req_i.bit_sel] = req_i.bit_val;
      end
      else
      begin
        next_port_d_direction = req_i.wdata;
      end
    end
    if (req_i.wr && hit(req_i.addr, `PORT_D_DATA_ADDR))
    begin
      if (req_i.bit_op)
      begin
        next_port_d_latch = pin_read;
        next_port_d_latch[req_i.bit_sel] = req_i.bit_val;
      end
      else
      begin
        next_port_d_latch = req_i.wdata;
      end
    end
  end

  // register update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_d_direction <= `PORT_D_DIRECTION_RESET;
      port_d_latch <= 8'h00;
    end
    else
    begin
      port_d_direction <= next_port_d_direction;
      port_d_latch <= next_port_d_latch;
    end
  end

  // read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (req_i.rd && hit(req_i.addr, `PORT_D_DATA_ADDR))
    begin
      rdata_o <= pin_read;
    end
    else if (req_i.rd && hit(req_i.addr, `PORT_D_DIRECTION_ADDR))
    begin
      rdata_o <= port_d_direction;
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // pad muxing
  // ****************************************
  always_comb
  begin
    pad.out = port_d_latch;
    pad.oe = ~port_d_direction;
    if (cmp_b_output_enable_i)
    begin
      pad.out[`PORT_D_PIN3_REFOUT] = refb_out_i;
      pad.oe[`PORT_D_PIN3_REFOUT] = 1'b1;
      pad.out[`PORT_D_PIN2_CMPOUT] = cmpb_out_i;
      pad.oe[`PORT_D_PIN2_CMPOUT] = 1'b1;
    end
    if (serial_enable_i && serial_pin_select_i)
    begin
      pad.out[`PORT_D_PIN1_SERIAL_DATA] = serial_data_out_i;
      pad.oe[`PORT_D_PIN1_SERIAL_DATA] = serial_data_oe_i;
      pad.out[`PORT_D_PIN0_SERIAL_CLOCK] = serial_clock_out_i;
      pad.oe[`PORT_D_PIN0_SERIAL_CLOCK] = serial_clock_oe_i;
    end
  end

  assign pin_o = pad.out;
  assign pin_oe_o = pad.oe;
  assign serial_pin_level_o = pin_sync[1:0];

  // ****************************************
  // assertions
  // ****************************************
  logic serial_own;
  assign serial_own = serial_enable_i && serial_pin_select_i;

  sequence s_bit_op_data;
    req_i.wr && req_i.bit_op && hit(req_i.addr, `PORT_D_DATA_ADDR);
  endsequence

  property p_direction_controls_oe;
    @(posedge clk_i) disable iff (rst_i)
      !cmp_b_output_enable_i && !serial_own |-> pin_oe_o == ~port_d_direction;
  endproperty
  a_direction_controls_oe: assert property (p_direction_controls_oe)
    else $error("output enable does not follow direction");

  property p_reset_direction;
    @(posedge clk_i) rst_i |=> port_d_direction == `PORT_D_DIRECTION_RESET
      && pin_oe_o[7:4] == 4'h0;
  endproperty
  a_reset_direction: assert property (p_reset_direction)
    else $error("direction not all ones after reset");

  property p_refout_pin3;
    @(posedge clk_i) disable iff (rst_i)
      cmp_b_output_enable_i |-> pin_oe_o[3] && pin_o[3] == refb_out_i;
  endproperty
  a_refout_pin3: assert property (p_refout_pin3)
    else $error("pin 3 not driving reference output");

  property p_cmpout_pin2;
    @(posedge clk_i) disable iff (rst_i)
      cmp_b_output_enable_i |-> pin_oe_o[2] && pin_o[2] == cmpb_out_i;
  endproperty
  a_cmpout_pin2: assert property (p_cmpout_pin2)
    else $error("pin 2 not driving comparator output");

  property p_read_pins;
    @(posedge clk_i) disable iff (rst_i)
      req_i.rd && hit(req_i.addr, `PORT_D_DATA_ADDR) |=> rdata_o == $past(pin_read);
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("data read did not return pin levels");

  property p_write_latch;
    @(posedge clk_i) disable iff (rst_i)
      req_i.wr && !req_i.bit_op && hit(req_i.addr, `PORT_D_DATA_ADDR)
      |=> port_d_latch == $past(req_i.wdata);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("data write not stored in latch");

  property p_bit_op_rmw;
    @(posedge clk_i) disable iff (rst_i)
      s_bit_op_data |=> port_d_latch[$past(req_i.bit_sel)] == $past(req_i.bit_val);
  endproperty
  a_bit_op_rmw: assert property (p_bit_op_rmw)
    else $error("bit operation did not set addressed bit");

  property p_bit_op_inputs;
    @(posedge clk_i) disable iff (rst_i)
      s_bit_op_data |=> ((port_d_latch ^ $past(pin_read)) & ~(8'h01 << $past(req_i.bit_sel)))
      == 8'h00;
  endproperty
  a_bit_op_inputs: assert property (p_bit_op_inputs)
    else $error("bit operation did not reload other latches from pins");

  property p_analog_reads_zero;
    @(posedge clk_i) disable iff (rst_i)
      req_i.rd && hit(req_i.addr, `PORT_D_DATA_ADDR) |=> (rdata_o[7:4] & $past(analog_select_i))
      == 4'h0;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog pin read nonzero");

  property p_serial_owns;
    @(posedge clk_i) disable iff (rst_i)
      serial_own |-> pin_oe_o[1:0] == {serial_data_oe_i, serial_clock_oe_i};
  endproperty
  a_serial_owns: assert property (p_serial_owns)
    else $error("serial does not own pins 1 and 0");

endmodule

// [design/port_d_defines.svh]
// register offsets, reset values and field positions for port d
`ifndef PORT_D_DEFINES_SVH
`define PORT_D_DEFINES_SVH
`define PORT_D_DATA_ADDR 8'h08
`define PORT_D_DIRECTION_ADDR 8'h88
`define PORT_D_DIRECTION_RESET 8'hff
`define PORT_D_PIN3_REFOUT 3
`define PORT_D_PIN2_CMPOUT 2
`define PORT_D_PIN1_SERIAL_DATA 1
`define PORT_D_PIN0_SERIAL_CLOCK 0
`endif

// [design/port_d_pkg.sv]
// types shared by the port d logic
package port_d_pkg;
  // one register file access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic bit_val;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  // pad control toward the pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad_drive_s;
endpackage

// [verification/port_d_ext_pins.sv]
// outside circuits resolving the port d pin levels
`timescale 1ns/1ps
module port_d_ext_pins
(
  // pad drive and outside drive
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_i,
  // resolved levels
  output logic [7:0] level_o
);
  // a driving pad wins, otherwise the outside circuit sets the level
  assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// [verification/tb_port_d_direction_and_latch.sv]
// self-checking bench for the port d block
`timescale 1ns/1ps
module tb_port_d_direction_and_latch;
  import port_d_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  reg_req_s req_i = '0;
  logic cmp_en = 1'b0;
  logic [7:0] alt = 8'h00;
  logic [3:0] ana = 4'h0;
  logic [7:0] ext = 8'h00;
  logic [7:0] rdata_o, pin_o, pin_oe_o, lvl, dir, lat, xl;
  logic [1:0] spl;
  integer seed = 32'h67eb;
  integer err_total = 0;
  integer tests_run = 0;
  integer n, e;

  // design and pin partner
  port_d_direction_and_latch dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .cmp_b_output_enable_i(cmp_en), .refb_out_i(alt[7]),
    .cmpb_out_i(alt[6]), .serial_pin_select_i(alt[5]), .serial_enable_i(alt[4]),
    .serial_data_out_i(alt[3]), .serial_data_oe_i(alt[2]), .serial_clock_out_i(alt[1]),
    .serial_clock_oe_i(alt[0]), .analog_select_i(ana), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .serial_pin_level_o(spl));
  port_d_ext_pins ext_pins (.pad_out_i(pin_o), .pad_oe_i(pin_oe_o), .ext_i(ext),
    .level_o(lvl));

  // clock
  initial forever #5 clk_i = ~clk_i;

  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one register access, taken at the edge after driving
  task acc(input logic w, r, b, v, input logic [2:0] s, input logic [7:0] a, d);
    @(negedge clk_i);
    req_i = '{wr: w, rd: r, bit_op: b, bit_val: v, bit_sel: s, addr: a, wdata: d};
    @(negedge clk_i);
    req_i = '0;
  endtask

  // expected pin levels from the model
  function logic [7:0] lv();
    return (~dir & lat) | (dir & ext);
  endfunction

  // verdict
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #200000;
    err_total++;
    stop_test;
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    dir = 8'hff;
    lat = 8'h00;
    acc(0, 1, 0, 0, 0, 8'h88, 0);
    chk(rdata_o, 8'hff);
    chk(pin_oe_o, 8'h00);
    acc(0, 1, 0, 0, 0, 8'h40, 0);
    chk(rdata_o, 8'h00);
    $display("test reset done");
    for (n = 0; n < 8; n++)
    begin
      lat = 8'($random(seed));
      ext = 8'($random(seed));
      ana = 4'($random(seed));
      acc(1, 0, 0, 0, 0, 8'h08, lat);
      dir = 8'($random(seed));
      acc(1, 0, 0, 0, 0, 8'h88, dir);
      chk(pin_oe_o, ~dir);
      chk(pin_o & ~dir, lat & ~dir);
      acc(0, 1, 0, 0, 0, 8'h88, 0);
      chk(rdata_o, dir);
      repeat (2) @(negedge clk_i);
      acc(0, 1, 0, 0, 0, 8'h08, 0);
      chk(rdata_o, lv() & {~ana, 4'hf});
      ana = 4'h0;
      e = $random(seed);
      acc(1, 0, 1, e[3], e[2:0], 8'h08, 0);
      lat = (lv() & ~(8'h01 << e[2:0])) | ({7'h00, e[3]} << e[2:0]);
      chk(pin_o & ~dir, lat & ~dir);
      dir = 8'h00;
      acc(1, 0, 0, 0, 0, 8'h88, dir);
      chk(pin_o, lat);
    end
    $display("test latch and pins done");
    for (n = 0; n < 16; n++)
    begin
      @(negedge clk_i);
      cmp_en = n[0];
      alt = 8'($random(seed));
      alt[5:4] = n[2:1];
      ext = 8'($random(seed));
      dir = 8'($random(seed));
      acc(1, 0, 0, 0, 0, 8'h88, dir);
      lat = 8'($random(seed));
      acc(1, 0, 0, 0, 0, 8'h08, lat);
      chk({4'h0, pin_oe_o[3:2], pin_o[3:2] & pin_oe_o[3:2]}, cmp_en ? {6'h03, alt[7:6]}
        : {4'h0, ~dir[3:2], lat[3:2] & ~dir[3:2]});
      chk({4'h0, pin_oe_o[1:0], pin_o[1:0] & pin_oe_o[1:0]}, (alt[5] & alt[4])
        ? {4'h0, alt[2], alt[0], alt[3] & alt[2], alt[1] & alt[0]}
        : {4'h0, ~dir[1:0], lat[1:0] & ~dir[1:0]});
      repeat (2) @(negedge clk_i);
      xl = lv();
      chk({6'h00, spl}, (alt[5] & alt[4])
        ? {6'h00, (alt[2] ? alt[3] : ext[1]), (alt[0] ? alt[1] : ext[0])}
        : {6'h00, xl[1:0]});
    end
    $display("test alternate functions done");
    stop_test;
  end
endmodule
